// ==== hdl/converter_control_register_bank.sv ====
// Purpose: write-only control registers of a dual converter, serial loaded
// Assumes: core_clk 10 MHz, serial_clock unrelated; frames spaced >= 4 core clocks
// Notes:   decoded controls are gated by extended_mode
`default_nettype none
// What this block does
// (RQ1) registers ignored outside extended control mode
// (RQ2) calibration bit ORed with pin, starts calibration
// (RQ3) host writes fixed reserved bit values
// (RQ4) single clock bit selects over-range or second clock
// (RQ5) stabilizer bit enables clock duty correction
// (RQ6) ddr phase bit sets 0 or 90 degrees
// (RQ7) ddr disable bit chooses ddr or sdr
// (RQ8) swing bit selects normal or reduced amplitude
// (RQ9) sdr: edge bit picks rising or falling
// (RQ10) ddr: edge bit picks demux; demux forces 0 degrees
// (RQ11) host writes configuration only at power-up
// (RQ12) i offset magnitude in bits 15:8
// (RQ13) bit 7 is offset sign
// (RQ14) q offset same encoding at address ah
// (RQ15) i full-scale 9-bit gain code, reset 100h
// (RQ16) host keeps gain codes in recommended range
// (RQ17) q full-scale same encoding at address bh
// (RQ18) test pattern bit drives outputs from generator
// (RQ19) trim skip keeps output clock running
// (RQ20) interleave enable runs both converters interleaved
// (RQ21) input select routes i or q input
// (RQ22) low frequency bit for slow interleave clocks
// (RQ23) 32-bit msb-first frame with fixed header
// (RQ24) back-to-back frames without deselect
// (RQ25) host avoids writes during calibration
// (RQ26) configuration register lives at address 1h
// (RQ27) update only on full valid frame
// (RQ28) power-on reset values; one calibration per write
module converter_control_register_bank (
  input  wire logic       core_clk,              // converter control clock
  input  wire logic       rst,                   // synchronous, active high
  input  wire logic       extended_mode,         // extended control selected
  input  wire logic       cal_pin,               // dedicated calibration pin
  input  wire logic       edge_select_pin,       // pin-mode edge select
  input  wire logic       swing_select_pin,      // pin-mode swing select
  input  wire logic       serial_clock,          // serial write clock
  input  wire logic       serial_select_n,       // serial frame select
  input  wire logic       serial_data_in,        // serial data
  output logic            cal_start_r,           // one-cycle calibration start
  output logic            single_clock_out_n_r,  // 1: one clock + over-range
  output logic            over_range_enable_r,   // over-range pin in use
  output logic            second_clock_enable_r, // second clock pin in use
  output logic            duty_cycle_stabilize_r,// duty correction on
  output logic            ddr_mode_r,            // ddr output clocking
  output logic            ddr_clock_phase_r,     // effective 90 degree phase
  output logic            output_swing_normal_r, // normal amplitude
  output logic            sdr_rising_edge_r,     // sdr data on rising edge
  output logic            demux_enable_r,        // 1:2 demultiplexed output
  output logic [7:0]      i_offset_mag_r,        // i offset magnitude
  output logic            i_offset_neg_r,        // i offset negative
  output logic [7:0]      q_offset_mag_r,        // q offset magnitude
  output logic            q_offset_neg_r,        // q offset negative
  output logic [8:0]      i_full_scale_r,        // i gain code
  output logic [8:0]      q_full_scale_r,        // q gain code
  output logic            pattern_output_enable_r,// test pattern on outputs
  output logic            trim_skip_r,           // skip termination trim
  output logic            clock_hold_on_r,       // output clock kept in cal
  output logic            interleave_enable_r,   // interleaved sampling
  output logic            interleave_input_select_r, // 1: q input
  output logic            interleave_low_freq_r  // slow-clock setting
);
  // ==========================================================
  // link side
  logic [31:0] frame_word;   // stable while toggle settles
  logic        frame_tgl;    // toggles per frame

  serial_frame_rx u_rx (
    .serial_clock    (serial_clock),
    .serial_select_n (serial_select_n),
    .serial_data_in  (serial_data_in),
    .frame_word_r    (frame_word),
    .frame_tgl_r     (frame_tgl)
  );

  // ==========================================================
  // crossing: toggle through three flops, edge once 2nd and 3rd differ
  logic tgl_s1_r;   // first stage, read only by tgl_s2_r
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic frame_evt;  // one core cycle per finished frame

  always_ff @(posedge core_clk) begin
    tgl_s1_r <= frame_tgl;
    tgl_s2_r <= tgl_s1_r;
    tgl_s3_r <= tgl_s2_r;
  end
  // the word was latched on the same serial edge that moved the toggle, so it is stable now
  assign frame_evt = tgl_s2_r ^ tgl_s3_r;

  // ==========================================================
  // frame decode
  logic        hdr_ok;     // header matches
  logic [3:0]  waddr;      // register address
  logic [15:0] wdata;      // register data
  logic        wr;         // valid write this cycle
  assign hdr_ok = frame_word[31:20] == ctrl_regs_pkg::FRAME_HEADER;
  assign waddr  = frame_word[19:16];
  assign wdata  = frame_word[15:0];
  assign wr     = frame_evt && hdr_ok; // RQ27

  // ==========================================================
  // register storage; reserved addresses match no case and are dropped
  logic [15:0] cfg_r;   // configuration
  logic [15:0] iofs_r;  // i offset
  logic [15:0] qofs_r;  // q offset
  logic [15:0] ifs_r;   // i full scale
  logic [15:0] qfs_r;   // q full scale
  logic [15:0] ext_r;   // extended configuration
  logic        cal_req_r; // pending write of the calibration bit

  // stored words; reset loads the power-on values
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_r  <= ctrl_regs_pkg::RST_CFG; // RQ28
      iofs_r <= ctrl_regs_pkg::RST_OFS;
      qofs_r <= ctrl_regs_pkg::RST_OFS;
      ifs_r  <= ctrl_regs_pkg::RST_FS;
      qfs_r  <= ctrl_regs_pkg::RST_FS;
      ext_r  <= ctrl_regs_pkg::RST_EXT;
    end else if (wr) begin
      case (waddr)
        ctrl_regs_pkg::ADDR_CFG:  cfg_r  <= wdata; // RQ26
        ctrl_regs_pkg::ADDR_IOFS: iofs_r <= wdata; // RQ12
        ctrl_regs_pkg::ADDR_QOFS: qofs_r <= wdata; // RQ14
        ctrl_regs_pkg::ADDR_IFS:  ifs_r  <= wdata; // RQ15
        ctrl_regs_pkg::ADDR_QFS:  qfs_r  <= wdata; // RQ17
        ctrl_regs_pkg::ADDR_EXT:  ext_r  <= wdata;
        default: ;                                 // RQ27
      endcase
    end
  end

  // calibration bit is not stored: each write of 1 is one request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_req_r <= 1'b0;
    end else begin
      cal_req_r <= wr && waddr == ctrl_regs_pkg::ADDR_CAL
                   && wdata[ctrl_regs_pkg::CAL_BIT]; // RQ28
    end
  end

  // ==========================================================
  // calibration pin: outside the domain, three flops, agree-filter
  logic cal_p1_r;  // first stage, read only by cal_p2_r
  logic cal_p2_r;
  logic cal_p3_r;
  logic cal_lvl_r; // filtered pin level
  always_ff @(posedge core_clk) begin
    cal_p1_r <= cal_pin;
    cal_p2_r <= cal_p1_r;
    cal_p3_r <= cal_p2_r;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_lvl_r <= 1'b0;
    end else if (cal_p2_r == cal_p3_r) begin
      cal_lvl_r <= cal_p3_r;
    end
  end

  // register request ORed with the pin; start on the rising edge of the OR
  logic cal_or_q_r;  // last OR level
  logic cal_or;
  assign cal_or = cal_lvl_r || (cal_req_r && extended_mode); // RQ2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_or_q_r  <= 1'b0;
      cal_start_r <= 1'b0;
    end else begin
      cal_or_q_r  <= cal_or;
      // a register write re-triggers even while the pin is held high
      cal_start_r <= (cal_or && !cal_or_q_r) || (cal_req_r && extended_mode); // RQ2
    end
  end

  // ==========================================================
  // effective controls: pin/default behaviour outside extended mode
  logic [15:0] cfg_e;  // configuration seen by logic
  logic [15:0] ext_e;
  logic [15:0] iofs_e;
  logic [15:0] qofs_e;
  logic [15:0] ifs_e;
  logic [15:0] qfs_e;
  logic        ddr_e;
  logic        oed_e;
  always_comb begin
    cfg_e  = extended_mode ? cfg_r  : ctrl_regs_pkg::RST_CFG; // RQ1
    ext_e  = extended_mode ? ext_r  : ctrl_regs_pkg::RST_EXT;
    iofs_e = extended_mode ? iofs_r : ctrl_regs_pkg::RST_OFS;
    qofs_e = extended_mode ? qofs_r : ctrl_regs_pkg::RST_OFS;
    ifs_e  = extended_mode ? ifs_r  : ctrl_regs_pkg::RST_FS;
    qfs_e  = extended_mode ? qfs_r  : ctrl_regs_pkg::RST_FS;
    ddr_e  = extended_mode && !cfg_r[ctrl_regs_pkg::CFG_NDE]; // RQ7
    oed_e  = extended_mode ? cfg_r[ctrl_regs_pkg::CFG_OED] : edge_select_pin;
  end

  // ==========================================================
  // output clocking controls
  always_ff @(posedge core_clk) begin
    if (rst) begin
      single_clock_out_n_r   <= 1'b1;
      over_range_enable_r    <= 1'b1;
      second_clock_enable_r  <= 1'b0;
      duty_cycle_stabilize_r <= 1'b1;
      ddr_mode_r             <= 1'b0;
      ddr_clock_phase_r      <= 1'b0;
      output_swing_normal_r  <= 1'b1;
      sdr_rising_edge_r      <= 1'b0;
      demux_enable_r         <= 1'b1;
    end else begin
      single_clock_out_n_r   <= cfg_e[ctrl_regs_pkg::CFG_NSD];  // RQ4
      over_range_enable_r    <= cfg_e[ctrl_regs_pkg::CFG_NSD];  // RQ4
      second_clock_enable_r  <= !cfg_e[ctrl_regs_pkg::CFG_NSD]; // RQ4
      duty_cycle_stabilize_r <= cfg_e[ctrl_regs_pkg::CFG_DCS];  // RQ5
      ddr_mode_r             <= ddr_e;                          // RQ7
      // phase only in ddr, and forced to 0 when demultiplexed
      ddr_clock_phase_r      <= ddr_e && oed_e
                                && cfg_e[ctrl_regs_pkg::CFG_DCP]; // RQ6 RQ10
      output_swing_normal_r  <= extended_mode ? cfg_r[ctrl_regs_pkg::CFG_OV]
                                              : swing_select_pin; // RQ8
      sdr_rising_edge_r      <= !ddr_e && oed_e;                // RQ9
      demux_enable_r         <= !(ddr_e && oed_e);              // RQ10
    end
  end

  // ==========================================================
  // trims: offset and gain codes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      i_offset_mag_r <= 8'h00;
      i_offset_neg_r <= 1'b0;
      q_offset_mag_r <= 8'h00;
      q_offset_neg_r <= 1'b0;
      i_full_scale_r <= 9'h100;
      q_full_scale_r <= 9'h100;
    end else begin
      i_offset_mag_r <= iofs_e[ctrl_regs_pkg::OFS_MAG_HI:ctrl_regs_pkg::OFS_MAG_LO]; // RQ12
      i_offset_neg_r <= iofs_e[ctrl_regs_pkg::OFS_SIGN]; // RQ13
      q_offset_mag_r <= qofs_e[ctrl_regs_pkg::OFS_MAG_HI:ctrl_regs_pkg::OFS_MAG_LO]; // RQ14
      q_offset_neg_r <= qofs_e[ctrl_regs_pkg::OFS_SIGN]; // RQ13
      i_full_scale_r <= ifs_e[ctrl_regs_pkg::FS_HI:ctrl_regs_pkg::FS_LO]; // RQ15
      q_full_scale_r <= qfs_e[ctrl_regs_pkg::FS_HI:ctrl_regs_pkg::FS_LO]; // RQ17
    end
  end

  // ==========================================================
  // extended configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pattern_output_enable_r   <= 1'b0;
      trim_skip_r               <= 1'b0;
      clock_hold_on_r           <= 1'b0;
      interleave_enable_r       <= 1'b0;
      interleave_input_select_r <= 1'b0;
      interleave_low_freq_r     <= 1'b0;
    end else begin
      pattern_output_enable_r   <= ext_e[ctrl_regs_pkg::EXT_TPO]; // RQ18
      trim_skip_r               <= ext_e[ctrl_regs_pkg::EXT_RTD]; // RQ19
      clock_hold_on_r           <= ext_e[ctrl_regs_pkg::EXT_RTD]; // RQ19
      interleave_enable_r       <= ext_e[ctrl_regs_pkg::EXT_DEN]; // RQ20
      interleave_input_select_r <= ext_e[ctrl_regs_pkg::EXT_IS];  // RQ21
      interleave_low_freq_r     <= ext_e[ctrl_regs_pkg::EXT_DLF]; // RQ22
    end
  end
endmodule // converter_control_register_bank
`default_nettype wire

// ==== hdl/ctrl_regs_pkg.sv ====
// Purpose: shared constants for the converter control register bank
// Assumes: 16-bit registers loaded by 32-bit serial frames
// Notes:   offsets are 4-bit frame addresses
`default_nettype none
package ctrl_regs_pkg;
  // ==========================================================
  // frame layout
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned HDR_BITS   = 12;
  localparam int unsigned ADDR_BITS  = 4;
  localparam int unsigned DATA_BITS  = 16;
  localparam logic [11:0] FRAME_HEADER = 12'h001;
  localparam logic [5:0]  CNT_LAST     = 6'h1f;
  // ==========================================================
  // register addresses
  localparam logic [3:0] ADDR_CAL   = 4'h0;
  localparam logic [3:0] ADDR_CFG   = 4'h1;
  localparam logic [3:0] ADDR_IOFS  = 4'h2;
  localparam logic [3:0] ADDR_IFS   = 4'h3;
  localparam logic [3:0] ADDR_EXT   = 4'h9;
  localparam logic [3:0] ADDR_QOFS  = 4'ha;
  localparam logic [3:0] ADDR_QFS   = 4'hb;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CAL  = 16'h7fff;
  localparam logic [15:0] RST_CFG  = 16'hb2ff;
  localparam logic [15:0] RST_OFS  = 16'h007f;
  localparam logic [15:0] RST_FS   = 16'h807f;
  localparam logic [15:0] RST_EXT  = 16'h03ff;
  // ==========================================================
  // field positions
  localparam int unsigned CAL_BIT      = 15;
  localparam int unsigned CFG_NSD      = 13;
  localparam int unsigned CFG_DCS      = 12;
  localparam int unsigned CFG_DCP      = 11;
  localparam int unsigned CFG_NDE      = 10;
  localparam int unsigned CFG_OV       = 9;
  localparam int unsigned CFG_OED      = 8;
  localparam int unsigned OFS_MAG_HI   = 15;
  localparam int unsigned OFS_MAG_LO   = 8;
  localparam int unsigned OFS_SIGN     = 7;
  localparam int unsigned FS_HI        = 15;
  localparam int unsigned FS_LO        = 7;
  localparam int unsigned EXT_TPO      = 15;
  localparam int unsigned EXT_RTD      = 14;
  localparam int unsigned EXT_DEN      = 13;
  localparam int unsigned EXT_IS       = 12;
  localparam int unsigned EXT_DLF      = 10;
endpackage : ctrl_regs_pkg
`default_nettype wire

// ==== hdl/serial_frame_rx.sv ====
// Purpose: link-clock shift register that captures 32-bit write frames
// Assumes: serial clock runs only around frames; select is active low
// Notes:   completed frames hand over through a toggle plus a held word
`default_nettype none
module serial_frame_rx (
  input  wire logic        serial_clock,    // link clock
  input  wire logic        serial_select_n, // frame select, low active
  input  wire logic        serial_data_in,  // data, msb first
  output logic [31:0]      frame_word_r,    // last complete frame
  output logic             frame_tgl_r      // toggles per complete frame
);
  // ==========================================================
  // shifting
  logic [5:0]  bit_cnt_r;   // bits taken in current frame
  logic [30:0] shift_r;     // first 31 bits of the frame
  logic        tgl_r = 1'b0; // no reset on this side: power-up value, core compares edges only

  // count bits; a new frame starts right on the 33rd edge; select high clears
  // at once, because the host may stop the clock right after a cut frame
  always_ff @(posedge serial_clock or posedge serial_select_n) begin
    if (serial_select_n) begin
      bit_cnt_r <= 6'h00;               // deselect drops partial frames
    end else if (bit_cnt_r == ctrl_regs_pkg::CNT_LAST) begin
      bit_cnt_r <= 6'h00;               // RQ24
    end else begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // msb-first shift on rising edges while selected
  always_ff @(posedge serial_clock) begin
    if (!serial_select_n) begin
      shift_r <= {shift_r[29:0], serial_data_in}; // RQ23
    end
  end

  // latch the whole frame on its 32nd bit; held until the next frame ends
  always_ff @(posedge serial_clock) begin
    if (!serial_select_n && bit_cnt_r == ctrl_regs_pkg::CNT_LAST) begin
      frame_word_r <= {shift_r, serial_data_in}; // RQ27
      tgl_r        <= ~tgl_r;
    end
  end

  assign frame_tgl_r = tgl_r;
endmodule // serial_frame_rx
`default_nettype wire

// ==== verif/bank_asserts.sv ====
// Purpose: port-level checks of the control register bank
// Assumes: core_clk domain only; rst synchronous active high
// Notes:   ties decoded outputs to each other and to extended_mode
`default_nettype none
module bank_asserts (
  input wire logic       core_clk,                // sampling clock
  input wire logic       rst,                     // disables checks
  input wire logic       extended_mode,           // register mode select
  input wire logic       cal_start_r,             // calibration start pulse
  input wire logic       single_clock_out_n_r,    // one clock plus over-range
  input wire logic       over_range_enable_r,     // over-range pin in use
  input wire logic       second_clock_enable_r,   // second clock pin in use
  input wire logic       ddr_mode_r,              // ddr clocking
  input wire logic       ddr_clock_phase_r,       // 90 degree phase
  input wire logic       sdr_rising_edge_r,       // sdr rising edge
  input wire logic       demux_enable_r,          // 1:2 demux
  input wire logic [8:0] i_full_scale_r,          // i gain code
  input wire logic [8:0] q_full_scale_r,          // q gain code
  input wire logic [7:0] i_offset_mag_r,          // i offset magnitude
  input wire logic       pattern_output_enable_r, // test pattern
  input wire logic       trim_skip_r,             // trim skip
  input wire logic       clock_hold_on_r          // clock kept in cal
);
  // ==========================================================
  // checks, all in the core clock domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_over_range_follow: assert property (over_range_enable_r == single_clock_out_n_r)
    else $error("over-range enable differs from single clock bit");
  a_second_clk_follow: assert property (second_clock_enable_r != single_clock_out_n_r)
    else $error("second clock enable not inverse of single clock bit");
  a_hold_follows_trim: assert property (clock_hold_on_r == trim_skip_r)
    else $error("clock hold differs from trim skip");
  a_sdr_edge_only: assert property (sdr_rising_edge_r |-> !ddr_mode_r)
    else $error("sdr edge select active in ddr mode");
  a_phase_needs_nodemux: assert property (ddr_clock_phase_r |-> ddr_mode_r && !demux_enable_r)
    else $error("90 degree phase outside ddr non-demux");
  a_nodemux_in_ddr: assert property (!demux_enable_r |-> ddr_mode_r)
    else $error("non-demux selected outside ddr");
  a_cal_one_cycle: assert property (cal_start_r |=> !cal_start_r)
    else $error("calibration start longer than one cycle");
  // registered outputs settle one edge after the mode drops
  a_nonext_defaults: assert property (!extended_mode ##1 !extended_mode |->
    i_full_scale_r == 9'h100 && q_full_scale_r == 9'h100 && i_offset_mag_r == 8'h00
    && !pattern_output_enable_r && !trim_skip_r)
    else $error("register values act outside extended mode");
  c_cal: cover property (cal_start_r);
  c_phase: cover property (ddr_clock_phase_r);
  c_nonext: cover property (!extended_mode ##1 !extended_mode);
endmodule // bank_asserts
`default_nettype wire

// ==== verif/host_serial_model.sv ====
// Purpose: host side of the three-wire write port
// Assumes: 30 ns serial clock, running only inside frames and for one arming pulse before the first
// Notes:   data changes while the clock is low; idle data shows inverse
`default_nettype none
module host_serial_model (
  output logic serial_clock,    // link clock, idle low
  output logic serial_select_n, // frame select, low active
  output logic serial_data_in   // data, msb first
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // one clock pulse with select high before the first frame arms the receiver
  initial begin
    serial_clock = 1'b0;
    serial_select_n = 1'b1;
    serial_data_in = 1'b0;
    #15 serial_clock = 1'b1;
    #15 serial_clock = 1'b0;
  end
  // ==========================================================
  // shift n bits msb first; hold keeps select low for a following frame
  task automatic send(input logic [31:0] w, input int n, input bit hold);
    serial_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_data_in = w[31-i];
      #15 serial_clock = 1'b1;
      #15 serial_clock = 1'b0;
    end
    // no stale level: a released line must not look driven; a held frame
    // goes straight on, so data is set only once in this time step
    if (!hold) begin
      serial_data_in = ~serial_data_in;
      serial_select_n = 1'b1;
      #15;
    end
  endtask
endmodule // host_serial_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the control register bank
// Assumes: 10 MHz core clock; rst, mode and pin inputs change on its falling edge, serial lines on the host's own 15 ns steps
// Notes:   outputs judged a fixed settle time after each frame
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, extended_mode, cal_pin, edge_select_pin, swing_select_pin;
  wire logic serial_clock, serial_select_n, serial_data_in;
  logic cal_start_r, single_clock_out_n_r, over_range_enable_r, second_clock_enable_r;
  logic duty_cycle_stabilize_r, ddr_mode_r, ddr_clock_phase_r, output_swing_normal_r;
  logic sdr_rising_edge_r, demux_enable_r, i_offset_neg_r, q_offset_neg_r;
  logic [7:0] i_offset_mag_r, q_offset_mag_r;
  logic [8:0] i_full_scale_r, q_full_scale_r;
  logic pattern_output_enable_r, trim_skip_r, clock_hold_on_r, interleave_enable_r;
  logic interleave_input_select_r, interleave_low_freq_r;
  int error_cnt, compares, cal_cnt;
  // ==========================================================
  // clock, host model and device
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  host_serial_model host (.serial_clock, .serial_select_n, .serial_data_in);
  converter_control_register_bank dut (.core_clk, .rst, .extended_mode, .cal_pin,
    .edge_select_pin, .swing_select_pin, .serial_clock, .serial_select_n, .serial_data_in,
    .cal_start_r, .single_clock_out_n_r, .over_range_enable_r, .second_clock_enable_r,
    .duty_cycle_stabilize_r, .ddr_mode_r, .ddr_clock_phase_r, .output_swing_normal_r,
    .sdr_rising_edge_r, .demux_enable_r, .i_offset_mag_r, .i_offset_neg_r, .q_offset_mag_r,
    .q_offset_neg_r, .i_full_scale_r, .q_full_scale_r, .pattern_output_enable_r,
    .trim_skip_r, .clock_hold_on_r, .interleave_enable_r, .interleave_input_select_r,
    .interleave_low_freq_r);
  // counts calibration start pulses; each pulse lasts one cycle
  always @(posedge core_clk) if (cal_start_r === 1'b1) cal_cnt <= cal_cnt + 1;
  // ==========================================================
  // shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // settle time covers the sync and decode latency with margin
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.send({ctrl_regs_pkg::FRAME_HEADER, a, d}, 32, 1'b0);
    repeat (10) @(negedge core_clk);
  endtask
  function automatic logic [7:0] cfg_view();
    return {single_clock_out_n_r, duty_cycle_stabilize_r, ddr_mode_r, ddr_clock_phase_r,
            output_swing_normal_r, sdr_rising_edge_r, demux_enable_r, second_clock_enable_r};
  endfunction
  function automatic logic [5:0] ext_view();
    return {pattern_output_enable_r, trim_skip_r, clock_hold_on_r, interleave_enable_r,
            interleave_input_select_r, interleave_low_freq_r};
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_defaults();
    chk(i_full_scale_r, 16'h0100);
    chk(q_full_scale_r, 16'h0100);
    chk({i_offset_neg_r, i_offset_mag_r}, 16'h0000);
    chk({q_offset_neg_r, q_offset_mag_r}, 16'h0000);
    chk(cfg_view(), 16'h00ea);
    chk(ext_view(), 16'h0000);
  endtask
  // ddr phase, forced 0 degrees in demux, then both sdr edges
  task automatic t_cfg();
    logic [15:0] v [4];
    logic [7:0]  e [4];
    v = '{16'h89ff, 16'h88ff, 16'hb7ff, 16'hb6ff};
    e = '{8'h31, 8'h23, 8'hce, 8'hca};
    for (int i = 0; i < 4; i++) begin
      wr(ctrl_regs_pkg::ADDR_CFG, v[i]);
      chk(cfg_view(), e[i]);
    end
  endtask
  // four frames with select held low throughout
  task automatic t_b2b();
    host.send({ctrl_regs_pkg::FRAME_HEADER, ctrl_regs_pkg::ADDR_IOFS, 16'hff7f}, 32, 1'b1);
    host.send({ctrl_regs_pkg::FRAME_HEADER, ctrl_regs_pkg::ADDR_QOFS, 16'h5aff}, 32, 1'b1);
    host.send({ctrl_regs_pkg::FRAME_HEADER, ctrl_regs_pkg::ADDR_IFS, 16'h607f}, 32, 1'b1);
    host.send({ctrl_regs_pkg::FRAME_HEADER, ctrl_regs_pkg::ADDR_QFS, 16'he07f}, 32, 1'b0);
    repeat (10) @(negedge core_clk);
    chk({i_offset_neg_r, i_offset_mag_r}, 16'h00ff);
    chk({q_offset_neg_r, q_offset_mag_r}, 16'h015a);
    chk(i_full_scale_r, 16'h00c0);
    chk(q_full_scale_r, 16'h01c0);
  endtask
  task automatic t_ext();
    wr(ctrl_regs_pkg::ADDR_EXT, 16'hf7ff);
    chk(ext_view(), 16'h003f);
  endtask
  // bad header, reserved address and a cut frame leave the gain alone
  task automatic t_refuse();
    wr(4'h3, 16'h707f);
    host.send({12'h002, ctrl_regs_pkg::ADDR_IFS, 16'he07f}, 32, 1'b0);
    wr(4'h5, 16'he07f);
    host.send({ctrl_regs_pkg::FRAME_HEADER, ctrl_regs_pkg::ADDR_IFS, 16'he07f}, 20, 1'b0);
    repeat (10) @(negedge core_clk);
    chk(i_full_scale_r, 16'h00e0);
    wr(ctrl_regs_pkg::ADDR_IFS, 16'h607f);
    chk(i_full_scale_r, 16'h00c0);
  endtask
  task automatic t_cal();
    int c0;
    c0 = cal_cnt;
    wr(ctrl_regs_pkg::ADDR_CAL, 16'hffff);
    chk(cal_cnt - c0, 16'h0001);
    wr(ctrl_regs_pkg::ADDR_CAL, 16'h7fff);
    chk(cal_cnt - c0, 16'h0001);
    // no frame is sent while the pin calibration runs
    cal_pin = 1'b1;
    repeat (10) @(negedge core_clk);
    cal_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(cal_cnt - c0, 16'h0002);
  endtask
  // pins take over outside extended mode; stored values return after
  task automatic t_nonext();
    int c0;
    c0 = cal_cnt;
    extended_mode = 1'b0;
    swing_select_pin = 1'b0;
    edge_select_pin = 1'b1;
    wr(ctrl_regs_pkg::ADDR_CAL, 16'hffff);
    chk(cal_cnt - c0, 16'h0000);
    chk({output_swing_normal_r, sdr_rising_edge_r, pattern_output_enable_r}, 16'h0002);
    chk(i_full_scale_r, 16'h0100);
    extended_mode = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({output_swing_normal_r, pattern_output_enable_r}, 16'h0003);
  endtask
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst, extended_mode, cal_pin, edge_select_pin, swing_select_pin} = 5'h18;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_defaults();
    t_cfg();
    t_b2b();
    t_ext();
    t_refuse();
    t_cal();
    t_nonext();
    give_verdict();
  end
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb
bind converter_control_register_bank bank_asserts chk_i (.core_clk, .rst, .extended_mode,
  .cal_start_r, .single_clock_out_n_r, .over_range_enable_r, .second_clock_enable_r,
  .ddr_mode_r, .ddr_clock_phase_r, .sdr_rising_edge_r, .demux_enable_r, .i_full_scale_r,
  .q_full_scale_r, .i_offset_mag_r, .pattern_output_enable_r, .trim_skip_r,
  .clock_hold_on_r);
`default_nettype wire
